// file: shared/sstx_pkg.sv
package sstx_pkg;

	localparam logic [9:0] IDX_RX_DATA = 10'h199;
	localparam logic [9:0] IDX_TX_HOLD = 10'h19a;
	localparam logic [9:0] IDX_DIV_LO = 10'h19b;
	localparam logic [9:0] IDX_DIV_HI = 10'h19c;
	localparam logic [9:0] IDX_RX_CTL = 10'h19d;
	localparam logic [9:0] IDX_TX_CTL = 10'h19e;
	localparam logic [9:0] IDX_BAUD_CTL = 10'h19f;
	localparam logic [9:0] IDX_IRQ_EN = 10'h1a0;

	localparam int TXC_CLK_SRC = 7;
	localparam int TXC_NINE_SEL = 6;
	localparam int TXC_TX_EN = 5;
	localparam int TXC_SYNC = 4;
	localparam int TXC_HOLD_EMPTY = 2;
	localparam int TXC_SHIFT_EMPTY = 1;
	localparam int TXC_NINTH = 0;
	localparam int RXC_PORT_EN = 7;
	localparam int RXC_SINGLE_RX = 5;
	localparam int RXC_CONT_RX = 4;
	localparam int BDC_CLK_POL = 4;
	localparam int BDC_DATA_LVL = 1;
	localparam int BDC_CLK_LVL = 0;
	localparam int IEN_TX = 0;
	localparam int IEN_PERIPH = 1;
	localparam int IEN_GLOBAL = 2;

	localparam logic [7:0] RST_TX_CTL = 8'h00;
	localparam logic [7:0] RST_RX_CTL = 8'h00;
	localparam logic [7:0] RST_BAUD_CTL = 8'h00;
	localparam logic [7:0] RST_DIV = 8'h00;
	localparam logic [7:0] RST_HOLD = 8'h00;
	localparam logic [2:0] RST_IRQ_EN = 3'h0;

	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_IDLE_HALF = 2'b01,
		ST_ACT_HALF = 2'b10
	} sstx_state_e;

endpackage

// file: rtl/sstx_top.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
// Contract
// - two lines only, data and clock; never send and receive together.
// - characters carry data bits only, no start or stop bit.
// - synchronous select bit puts the port in synchronous operation.
// - clock source bit makes the port master, driving the bit clock.
// - both receive enables clear means transmit; either set means receive.
// - port works only while serial port enable is set.
// - master drives clock pin, its driver enabled automatically.
// - data changes on leading clock edge, valid at trailing edge.
// - exactly one clock cycle per data bit, no extra cycles.
// - polarity set: clock idles high, data changes on falling edge.
// - polarity clear: clock idles low, data changes on rising edge.
// - master transmit drives data pin; data and clock drivers enabled.
// - writing the holding buffer starts a transmission.
// - new character waits in holding buffer until shifter is done.
// - empty shifter takes a written character from holding at once.
// - shifting starts right after transfer into the shifter.
// - each bit holds from one leading edge to the next.
// - shift register has no address and is not software visible.
// - transmit works only while transmit enable bit is set.
// - nine-bit select sends nine bits, ninth from a control bit.
// - transmit interrupt needs its enable plus global and peripheral.
module sstx_top
	import sstx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_n,
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe_n,
	output logic tx_irq
);

	function automatic logic reg_hit(input logic [31:0] a,
		input logic [9:0] idx);
		reg_hit = (a == {20'h00000, idx, 2'b00});
	endfunction

	logic dp_wr_q;
	logic dp_rd_q;
	logic dp_word_q;
	logic [31:0] dp_addr_q;
	logic rd_done_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_mux;
	logic ap_take;
	logic wr_en;

	logic clk_src_q;
	logic nine_sel_q;
	logic tx_en_q;
	logic sync_q;
	logic ninth_q;
	logic port_en_q;
	logic single_rx_q;
	logic cont_rx_q;
	logic clk_pol_q;
	logic [7:0] div_lo_q;
	logic [7:0] div_hi_q;
	logic [2:0] irq_en_q;
	logic [8:0] hold_q;
	logic hold_full_q;
	logic hold_full_d;

	logic ck_s1_q;
	logic ck_s2_q;
	logic dt_s1_q;
	logic dt_s2_q;

	sstx_state_e state_q;
	logic [15:0] cnt_q;
	logic [3:0] bits_q;
	logic [8:0] shift_q;
	logic clk_act_q;
	logic dat_q;

	logic master_on;
	logic tx_mode;
	logic hold_wr;
	logic last_trail;
	logic load;
	logic [15:0] div_val;

	assign div_val = {div_hi_q, div_lo_q};
	// master clock whenever synchronous master, tx or rx
	assign master_on = port_en_q & sync_q & clk_src_q;
	// receive enables steal the data line from the transmitter
	assign tx_mode = master_on & tx_en_q & ~single_rx_q & ~cont_rx_q;

	// ---------------- bus slave ----------------
	assign ap_take = hsel & htrans[1] & hready;
	assign wr_en = dp_wr_q & dp_word_q & hready;
	assign hold_wr = wr_en & reg_hit(dp_addr_q, IDX_TX_HOLD);
	// one wait state on reads keeps hrdata registered and fresh
	assign hreadyout = ~(dp_rd_q & ~rd_done_q);
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_word_q <= 1'b0;
			dp_addr_q <= 32'h00000000;
			rd_done_q <= 1'b0;
			hrdata_q <= 32'h00000000;
		end else if (hready) begin
			dp_wr_q <= ap_take & hwrite;
			dp_rd_q <= ap_take & ~hwrite;
			dp_word_q <= (hsize == HSIZE_WORD);
			dp_addr_q <= haddr;
			rd_done_q <= 1'b0;
		end else if (dp_rd_q) begin
			hrdata_q <= rd_mux;
			rd_done_q <= 1'b1;
		end
	end

	// the shifter is deliberately absent from this map
	always_comb begin
		rd_mux = 32'h00000000;
		if (reg_hit(dp_addr_q, IDX_TX_HOLD)) begin
			rd_mux[7:0] = hold_q[7:0];
		end else if (reg_hit(dp_addr_q, IDX_DIV_LO)) begin
			rd_mux[7:0] = div_lo_q;
		end else if (reg_hit(dp_addr_q, IDX_DIV_HI)) begin
			rd_mux[7:0] = div_hi_q;
		end else if (reg_hit(dp_addr_q, IDX_RX_CTL)) begin
			rd_mux[RXC_PORT_EN] = port_en_q;
			rd_mux[RXC_SINGLE_RX] = single_rx_q;
			rd_mux[RXC_CONT_RX] = cont_rx_q;
		end else if (reg_hit(dp_addr_q, IDX_TX_CTL)) begin
			rd_mux[TXC_CLK_SRC] = clk_src_q;
			rd_mux[TXC_NINE_SEL] = nine_sel_q;
			rd_mux[TXC_TX_EN] = tx_en_q;
			rd_mux[TXC_SYNC] = sync_q;
			rd_mux[TXC_HOLD_EMPTY] = ~hold_full_q;
			rd_mux[TXC_SHIFT_EMPTY] = (state_q == ST_IDLE);
			rd_mux[TXC_NINTH] = ninth_q;
		end else if (reg_hit(dp_addr_q, IDX_BAUD_CTL)) begin
			rd_mux[BDC_CLK_POL] = clk_pol_q;
			rd_mux[BDC_DATA_LVL] = dt_s2_q;
			rd_mux[BDC_CLK_LVL] = ck_s2_q;
		end else if (reg_hit(dp_addr_q, IDX_IRQ_EN)) begin
			rd_mux[2:0] = irq_en_q;
		end
	end

	// ---------------- control registers ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_src_q <= RST_TX_CTL[TXC_CLK_SRC];
			nine_sel_q <= RST_TX_CTL[TXC_NINE_SEL];
			tx_en_q <= RST_TX_CTL[TXC_TX_EN];
			sync_q <= RST_TX_CTL[TXC_SYNC];
			ninth_q <= RST_TX_CTL[TXC_NINTH];
			port_en_q <= RST_RX_CTL[RXC_PORT_EN];
			single_rx_q <= RST_RX_CTL[RXC_SINGLE_RX];
			cont_rx_q <= RST_RX_CTL[RXC_CONT_RX];
			clk_pol_q <= RST_BAUD_CTL[BDC_CLK_POL];
			div_lo_q <= RST_DIV;
			div_hi_q <= RST_DIV;
			irq_en_q <= RST_IRQ_EN;
		end else if (wr_en) begin
			if (reg_hit(dp_addr_q, IDX_TX_CTL)) begin
				clk_src_q <= hwdata[TXC_CLK_SRC];
				nine_sel_q <= hwdata[TXC_NINE_SEL];
				tx_en_q <= hwdata[TXC_TX_EN];
				sync_q <= hwdata[TXC_SYNC];
				ninth_q <= hwdata[TXC_NINTH];
			end
			if (reg_hit(dp_addr_q, IDX_RX_CTL)) begin
				port_en_q <= hwdata[RXC_PORT_EN];
				single_rx_q <= hwdata[RXC_SINGLE_RX];
				cont_rx_q <= hwdata[RXC_CONT_RX];
			end
			if (reg_hit(dp_addr_q, IDX_BAUD_CTL)) begin
				clk_pol_q <= hwdata[BDC_CLK_POL];
			end
			if (reg_hit(dp_addr_q, IDX_DIV_LO)) begin
				div_lo_q <= hwdata[7:0];
			end
			if (reg_hit(dp_addr_q, IDX_DIV_HI)) begin
				div_hi_q <= hwdata[7:0];
			end
			if (reg_hit(dp_addr_q, IDX_IRQ_EN)) begin
				irq_en_q <= hwdata[2:0];
			end
		end
	end

	// ---------------- holding buffer ----------------
	// a write in the transfer cycle refills it, so full must stay set
	always_comb begin
		hold_full_d = hold_full_q;
		if (load) begin
			hold_full_d = 1'b0;
		end
		if (hold_wr) begin
			hold_full_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_q <= {1'b0, RST_HOLD};
			hold_full_q <= 1'b0;
		end else begin
			hold_full_q <= hold_full_d;
			if (hold_wr) begin
				// ninth bit latched from the control bit set beforehand
				hold_q <= {ninth_q, hwdata[7:0]};
			end
		end
	end

	// ---------------- pin level sampling ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			dt_s1_q <= 1'b0;
			dt_s2_q <= 1'b0;
		end else begin
			ck_s1_q <= clk_pin_in;
			ck_s2_q <= ck_s1_q;
			dt_s1_q <= data_pin_in;
			dt_s2_q <= dt_s1_q;
		end
	end

	// ---------------- shift engine ----------------
	assign last_trail = (state_q == ST_ACT_HALF) & (cnt_q == 16'h0000) &
		(bits_q == 4'h1);
	// only an empty shifter takes the next character
	assign load = tx_mode & hold_full_q &
		((state_q == ST_IDLE) | last_trail);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			bits_q <= 4'h0;
			shift_q <= 9'h000;
			clk_act_q <= 1'b0;
			dat_q <= 1'b0;
		end else if (!tx_mode) begin
			// dropping out of transmit aborts the character
			state_q <= ST_IDLE;
			clk_act_q <= 1'b0;
			bits_q <= 4'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (load) begin
						// raw data bits only, no framing
						shift_q <= hold_q;
						bits_q <= nine_sel_q ? BITS_NINE : BITS_EIGHT;
						cnt_q <= div_val;
						state_q <= ST_IDLE_HALF;
					end
				end
				ST_IDLE_HALF: begin
					if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else begin
						// leading edge: new bit goes out, lsb first
						clk_act_q <= 1'b1;
						dat_q <= shift_q[0];
						shift_q <= {1'b0, shift_q[8:1]};
						cnt_q <= div_val;
						state_q <= ST_ACT_HALF;
					end
				end
				ST_ACT_HALF: begin
					if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else begin
						// trailing edge: slave samples, one cycle per bit
						clk_act_q <= 1'b0;
						cnt_q <= div_val;
						if (load) begin
							shift_q <= hold_q;
							bits_q <= nine_sel_q ? BITS_NINE : BITS_EIGHT;
							state_q <= ST_IDLE_HALF;
						end else if (bits_q == 4'h1) begin
							bits_q <= 4'h0;
							state_q <= ST_IDLE;
						end else begin
							bits_q <= bits_q - 4'h1;
							state_q <= ST_IDLE_HALF;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ---------------- pins and interrupt ----------------
	// polarity only inverts the wire, so edge roles follow it
	assign clk_pin_out = clk_pol_q ^ clk_act_q;
	assign clk_pin_oe_n = ~master_on;
	assign data_pin_out = dat_q;
	assign data_pin_oe_n = ~tx_mode;
	assign tx_irq = ~hold_full_q & irq_en_q[IEN_TX] &
		irq_en_q[IEN_PERIPH] & irq_en_q[IEN_GLOBAL];

	// ---------------- assertions ----------------
	AST_CLK_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
		master_on |-> !clk_pin_oe_n)
		else $error("clock pin not driven in master mode");

	AST_DATA_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
		(single_rx_q || cont_rx_q) |-> data_pin_oe_n)
		else $error("data pin driven while receive selected");

	AST_IDLE_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_IDLE) |-> (clk_pin_out == clk_pol_q))
		else $error("clock not at idle level when idle");

	AST_DATA_ON_LEAD: assert property (@(posedge hclk)
		disable iff (!hresetn)
		$changed(dat_q) |-> (clk_act_q && !$past(clk_act_q)))
		else $error("data changed away from leading edge");

	AST_NINE_BITS: assert property (@(posedge hclk) disable iff (!hresetn)
		(load && nine_sel_q) |=> (bits_q == 4'h9))
		else $error("nine-bit character not nine bits");

	AST_HOLD_WAITS: assert property (@(posedge hclk) disable iff (!hresetn)
		(hold_full_q && state_q == ST_ACT_HALF && bits_q > 4'h1)
		|=> hold_full_q)
		else $error("holding buffer drained before shifter empty");

	AST_IMMEDIATE: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_mode && state_q == ST_IDLE && hold_full_q && !hold_wr)
		|=> (state_q == ST_IDLE_HALF && !hold_full_q))
		else $error("idle shifter did not take held character");

	AST_WRITE_STARTS: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(hold_wr && tx_mode && state_q == ST_IDLE && !hold_full_q)
		##1 tx_mode |=> (state_q == ST_IDLE_HALF))
		else $error("write did not start a transmission");

	AST_PORT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		!port_en_q |-> (data_pin_oe_n && clk_pin_oe_n) ##1
		(state_q == ST_IDLE))
		else $error("port active while disabled");

	AST_IRQ_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_irq |-> (irq_en_q == 3'h7 && !hold_full_q))
		else $error("interrupt without all enables");

	AST_BIT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_ACT_HALF && cnt_q == 16'h0000 && !load)
		|=> $stable(dat_q))
		else $error("data moved at trailing edge");

endmodule

// file: tb/sstx_slave_model.sv
`timescale 1ns/100ps
module sstx_slave_model (
	input wire logic clk_line,
	input wire logic data_line,
	input wire logic pol,
	input wire logic data_oe_n,
	output logic slv_dat
);
	logic rx_q[$];

	initial begin
		slv_dat = 1'b0;
	end
	// sample on the trailing edge, only while the master drives data
	always @(posedge clk_line) begin
		if (pol && !data_oe_n) begin
			rx_q.push_back(data_line);
		end
	end
	always @(negedge clk_line) begin
		if (!pol && !data_oe_n) begin
			rx_q.push_back(data_line);
		end
	end
	// never drive during master transmit; when released, show the
	// inverse of the last bit so a stale value cannot pass as data
	always @(data_oe_n) begin
		slv_dat = ~data_line;
	end
	always @(clk_line) begin
		if (data_oe_n) begin
			slv_dat = ~slv_dat;
		end
	end
endmodule

// file: tb/sync_serial_master_tx_test.sv
`timescale 1ns/100ps
module sync_serial_master_tx_test import sstx_pkg::*;;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, cko, ckoe_n, dto, dtoe_n, tx_irq;
	logic ck_line, dt_line, slv_dat, pol_b;
	logic [7:0] rv, ch;
	logic ninth;
	int bad_count = 0;
	int num_checks = 0;
	int exp_q[$];
	logic [9:0] zt[6] = '{IDX_RX_DATA, IDX_DIV_LO, IDX_DIV_HI, IDX_RX_CTL,
		IDX_IRQ_EN, 10'h1a1};

	always #12.5 hclk = ~hclk;
	// wire levels from the pin enables of sstx_top alone
	assign ck_line = ckoe_n ? ~cko : cko;
	assign dt_line = dtoe_n ? slv_dat : dto;

	sstx_top sstx_top_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .clk_pin_in(ck_line), .clk_pin_out(cko),
		.clk_pin_oe_n(ckoe_n), .data_pin_in(dt_line), .data_pin_out(dto),
		.data_pin_oe_n(dtoe_n), .tx_irq(tx_irq)
	);
	sstx_slave_model sstx_slave_model_i (
		.clk_line(ck_line), .data_line(dt_line), .pol(pol_b),
		.data_oe_n(dtoe_n), .slv_dat(slv_dat)
	);

	task test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// bounded wait for hready sampled high at a rising edge
	task hs;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 40) begin
				bad_count++;
				test_done();
			end
			@(posedge hclk);
		end
	endtask

	task bus(input logic [9:0] idx, input logic w, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, idx, 2'h0};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		hs();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		hs();
		rv = hrdata[7:0];
	endtask

	task wr(input logic [9:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
		// the write lands at the edge just taken: let it settle
		@(posedge hclk);
	endtask

	task rd(input logic [9:0] idx);
		bus(idx, 1'b0, 8'h00);
	endtask

	task wait_idle;
		int n;
		n = 0;
		rd(IDX_TX_CTL);
		while (rv[2:1] !== 2'b11) begin
			n++;
			if (n > 300) begin
				bad_count++;
				test_done();
			end
			rd(IDX_TX_CTL);
		end
	endtask

	// queue a character in the bench model and write it
	task send(input logic [7:0] c, input logic nine);
		for (int b = 0; b < 8; b++) begin
			exp_q.push_back(c[b]);
		end
		if (nine) begin
			exp_q.push_back(ninth);
		end
		wr(IDX_TX_HOLD, c);
	endtask

	task cmp_bits;
		chk("bit count", exp_q.size(), sstx_slave_model_i.rx_q.size());
		foreach (exp_q[i]) begin
			chk("bit", exp_q[i], sstx_slave_model_i.rx_q[i]);
		end
		exp_q.delete();
		sstx_slave_model_i.rx_q.delete();
	endtask

	initial begin
		void'($urandom(32'h0528));
		pol_b = 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(IDX_TX_CTL);
		chk("txctl reset", 9'h006, rv);
		foreach (zt[i]) begin
			rd(zt[i]);
			chk("reg reset", 9'h000, rv);
		end
		ch = 8'($urandom_range(0, 3));
		wr(IDX_DIV_LO, ch);
		rd(IDX_DIV_LO);
		chk("div lo", ch, rv);
		$display("test registers done");
		wr(IDX_RX_CTL, 8'h80);
		for (int m = 0; m < 4; m++) begin
			ninth = 1'($urandom);
			wr(IDX_TX_CTL, 8'h00);
			wr(IDX_BAUD_CTL, {3'h0, m[0], 4'h0});
			pol_b = m[0];
			wr(IDX_TX_CTL, {3'h5, 1'b1, 3'h0, ninth} | {1'b0, m[1], 6'h0});
			chk("clk idle", m[0], cko);
			chk("clk oe", 9'h0, ckoe_n);
			chk("data oe", 9'h0, dtoe_n);
			sstx_slave_model_i.rx_q.delete();
			send(8'($urandom), m[1]);
			send(8'($urandom), m[1]);
			rd(IDX_TX_CTL);
			chk("hold waits", 9'h0, rv[2]);
			wait_idle();
			cmp_bits();
			chk("clk back idle", m[0], cko);
			$display("test mode %0d done", m);
		end
		wr(IDX_RX_CTL, 8'ha0);
		chk("data oe single rx", 9'h1, dtoe_n);
		chk("clk oe single rx", 9'h0, ckoe_n);
		wr(IDX_RX_CTL, 8'h90);
		chk("data oe cont rx", 9'h1, dtoe_n);
		wr(IDX_RX_CTL, 8'h00);
		chk("clk oe port off", 9'h1, ckoe_n);
		chk("data oe port off", 9'h1, dtoe_n);
		rd(IDX_BAUD_CTL);
		chk("pin levels", {4'h0, pol_b, 2'h0, dt_line, ck_line}, rv);
		$display("test modes done");
		wr(IDX_RX_CTL, 8'h80);
		wr(IDX_TX_CTL, 8'h90);
		wr(IDX_IRQ_EN, 8'h07);
		chk("irq empty", 9'h1, tx_irq);
		ninth = 1'b0;
		// drop edges seen while the pin drivers were switching
		sstx_slave_model_i.rx_q.delete();
		send(8'h5a, 1'b0);
		repeat (40) @(posedge hclk);
		rd(IDX_TX_CTL);
		chk("hold kept", 9'h0, rv[2]);
		chk("irq full", 9'h0, tx_irq);
		wr(IDX_TX_CTL, 8'hb0);
		wait_idle();
		chk("irq again", 9'h1, tx_irq);
		cmp_bits();
		wr(IDX_IRQ_EN, 8'h03);
		chk("irq gated", 9'h0, tx_irq);
		wr(IDX_IRQ_EN, 8'h05);
		chk("irq no periph", 9'h0, tx_irq);
		$display("test irq done");
		test_done();
	end
endmodule
